/* File: rt_settings_pkg.sv */
/*
  Constants and types shared by the run-time settings decoder: report layout,
  field positions, register offsets, interrupt bits and state encodings.
  Assumes a 64-byte command report delivered one byte per strobe.
*/
`default_nettype none
package rt_settings_pkg;
  // ----------------------------------------------------------------
  // Report layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_RUNTIME = 8'h60;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_FILL = 8'h00;
  localparam logic [5:0] IDX_CODE = 6'h00;
  localparam logic [5:0] IDX_ADC = 6'h05;
  localparam logic [5:0] IDX_INT = 6'h06;
  localparam logic [5:0] IDX_GATE = 6'h07;
  localparam logic [5:0] IDX_PIN0 = 6'h08;
  localparam logic [5:0] IDX_LAST = 6'h3f;
  // ----------------------------------------------------------------
  // Bit positions inside the command bytes
  // ----------------------------------------------------------------
  localparam int LOAD_BIT = 7;
  localparam int ADC_LVL_LO = 1;
  localparam int ADC_SRC_BIT = 0;
  localparam int RISE_EN_BIT = 4;
  localparam int RISE_VAL_BIT = 3;
  localparam int FALL_EN_BIT = 2;
  localparam int FALL_VAL_BIT = 1;
  localparam int FLAG_CLR_BIT = 0;
  localparam int PIN_VAL_BIT = 4;
  localparam int PIN_DIR_BIT = 3;
  localparam int PIN_DES_LO = 0;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_SETTINGS = 8'h08;
  localparam int IRQ_W = 3;
  localparam int IRQ_APPLIED = 0;
  localparam int IRQ_DETECT = 1;
  localparam int IRQ_FOREIGN = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam int SF_LVL = 0;
  localparam int SF_SRC = 2;
  localparam int SF_RISE = 3;
  localparam int SF_FALL = 4;
  localparam int SF_FLAG = 5;
  localparam int SF_DES = 6;
  localparam int SF_DIR = 9;
  localparam int SF_VAL = 10;
  localparam int SF_PIN = 16;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REF_OFF = 2'h0, REF_1V024 = 2'h1, REF_2V048 = 2'h2, REF_4V096 = 2'h3
  } ref_level_t;
  localparam logic [2:0] DES_GPIO = 3'h0;
  localparam logic [2:0] DES_SUSPEND = 3'h1;
  localparam logic [2:0] DES_RX_LED = 3'h2;
  typedef enum logic [1:0] {RSP_IDLE = 2'b01, RSP_SEND = 2'b10} rsp_state_t;
endpackage : rt_settings_pkg
`default_nettype wire

/* File: cmd_if.sv */
/*
  Carrier for a captured command: commit pulse and the four decoded bytes.
  Assumes one source (report capture) and one sink (the decoder top).
*/
`timescale 1ns/1ns
`default_nettype none
interface cmd_if;
  logic commit;
  logic foreign;
  logic [7:0] adc_b;
  logic [7:0] int_b;
  logic [7:0] gate_b;
  logic [7:0] pin_b;
  modport src (output commit, foreign, adc_b, int_b, gate_b, pin_b);
  modport dst (input commit, foreign, adc_b, int_b, gate_b, pin_b);
endinterface : cmd_if
`default_nettype wire

/* File: report_capture.sv */
/*
  Collects one 64-byte command report and hands bytes 5 to 8 over together.
  Assumes bytes arrive in order, first_in marking byte 0, on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module report_capture (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic byte_valid_in,
  input wire logic first_in,
  input wire logic [7:0] byte_in,
  cmd_if.src cmd
);
  import rt_settings_pkg::*;

  typedef struct packed {
    logic [5:0] idx;
    logic active;
    logic code_ok;
    logic [7:0] adc_b;
    logic [7:0] int_b;
    logic [7:0] gate_b;
    logic [7:0] pin_b;
    logic commit;
    logic foreign;
  } cap_t;

  cap_t s_q, s_d;
  logic [5:0] pos;
  logic ok;

  always_comb begin
    s_d = s_q;
    s_d.commit = 1'b0;
    s_d.foreign = 1'b0;
    pos = first_in ? IDX_CODE : s_q.idx;
    ok = (pos == IDX_CODE) ? (byte_in == CMD_SET_RUNTIME) : s_q.code_ok;
    if (byte_valid_in && (first_in || s_q.active)) begin
      s_d.active = 1'b1;
      s_d.code_ok = ok;
      s_d.idx = pos + 6'h01;
      if (pos == IDX_ADC) s_d.adc_b = byte_in;
      if (pos == IDX_INT) s_d.int_b = byte_in;
      if (pos == IDX_GATE) s_d.gate_b = byte_in;
      if (pos == IDX_PIN0) s_d.pin_b = byte_in;
      if (pos == IDX_LAST) begin
        s_d.active = 1'b0;
        s_d.commit = ok;
        s_d.foreign = !ok;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd.commit = s_q.commit;
  assign cmd.foreign = s_q.foreign;
  assign cmd.adc_b = s_q.adc_b;
  assign cmd.int_b = s_q.int_b;
  assign cmd.gate_b = s_q.gate_b;
  assign cmd.pin_b = s_q.pin_b;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_commit_on_code: assert property (
    byte_valid_in && !first_in && s_q.active && s_q.idx == IDX_LAST
    |=> cmd.commit == $past(s_q.code_ok) && cmd.foreign == !$past(s_q.code_ok))
    else $error("report end did not commit per command code");
endmodule : report_capture
`default_nettype wire

/* File: int_edge_detect.sv */
/*
  Edge detector with a sticky detection flag for the interrupt input.
  Assumes the input is synchronous to the clock; a set beats a clear.
*/
`timescale 1ns/1ns
`default_nettype none
module int_edge_detect (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic pin_in,
  input wire logic rise_en_in,
  input wire logic fall_en_in,
  input wire logic clear_in,
  output logic flag_out,
  output logic set_out
);
  typedef struct packed {
    logic prev;
    logic primed;
    logic flag;
    logic set;
  } edge_t;

  edge_t s_q, s_d;
  logic hit;

  always_comb begin
    s_d = s_q;
    hit = s_q.primed && ((rise_en_in && pin_in && !s_q.prev) ||
                         (fall_en_in && !pin_in && s_q.prev));
    s_d.prev = pin_in;
    s_d.primed = 1'b1;
    s_d.flag = hit | (s_q.flag & ~clear_in);
    s_d.set = hit;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_out = s_q.flag;
  assign set_out = s_q.set;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_flag_clear_works: assert property (clear_in && !hit |=> !flag_out)
    else $error("detection flag survived a clear");
  a_flag_kept: assert property (!clear_in && flag_out |=> flag_out)
    else $error("detection flag dropped without a clear");
  a_rise_triggers: assert property (
    s_q.primed && rise_en_in && pin_in && !s_q.prev |=> flag_out && set_out)
    else $error("enabled rising edge did not set the flag");
endmodule : int_edge_detect
`default_nettype wire

/* File: runtime_settings_decoder.sv */
/*
  Run-time settings decoder: applies ADC reference, interrupt detection and
  general pin zero settings from a 0x60 command report, answers with a status
  report, and offers status, mask and readback registers on a plain port.
  Assumes a single 100 MHz clock, synchronous inputs and a one-cycle bus.
*/
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Byte 0 equal to 0x60 marks a run-time settings command.
// - Settings are volatile; reset restores the power-up defaults.
// - Reply carries 0x60 in byte 0 and 0x00 in byte 1.
// - Byte 5 bit 7 set loads ADC reference from bits 2 to 0.
// - Level field: 11 4.096 V, 10 2.048 V, 01 1.024 V, 00 off.
// - Byte 5 bit 0 picks internal reference (1) or supply rail (0).
// - Byte 6 takes effect only when its bit 7 is set.
// - Byte 6 bit 4 set loads rising-edge trigger from bit 3.
// - Byte 6 bit 2 set loads falling-edge trigger from bit 1.
// - Byte 6 bit 0 set clears the detection flag.
// - Byte 7 bit 7 set loads pin zero settings from byte 8.
// - As general-purpose output, pin zero drives byte 8 bit 4.
// - Byte 8 bit 3 sets direction, 1 input, only in general-purpose use.
// - Byte 8 bits 2 to 0: 000 general, 001 suspend, 010 receive LED.
module runtime_settings_decoder #(
  parameter rt_settings_pkg::ref_level_t DEF_ADC_LEVEL = rt_settings_pkg::REF_OFF,
  parameter logic DEF_ADC_INTERNAL = 1'b0,
  parameter logic DEF_RISE_EN = 1'b0,
  parameter logic DEF_FALL_EN = 1'b0,
  parameter logic [2:0] DEF_PIN_DES = 3'h0,
  parameter logic DEF_PIN_DIR = 1'b1,
  parameter logic DEF_PIN_VAL = 1'b0
) (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CMD_BYTE_VALID_IN,
  input wire logic CMD_FIRST_IN,
  input wire logic [7:0] CMD_BYTE_IN,
  output logic RESP_VALID_OUT,
  output logic RESP_LAST_OUT,
  output logic [7:0] RESP_BYTE_OUT,
  output logic [1:0] ADC_REF_LEVEL_OUT,
  output logic ADC_REF_INTERNAL_OUT,
  input wire logic INT_DETECT_PIN_IN,
  output logic INT_DETECT_FLAG_OUT,
  input wire logic SUSPEND_STATE_IN,
  input wire logic UART_RX_ACTIVE_IN,
  input wire logic GENERAL_PIN_ZERO_IN,
  output logic GENERAL_PIN_ZERO_OUT,
  output logic GENERAL_PIN_ZERO_OE_OUT,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic IRQ_OUT
);
  import rt_settings_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ref_level_t adc_lvl;
    logic adc_int;
    logic rise_en;
    logic fall_en;
    logic [2:0] pin_des;
    logic pin_dir;
    logic pin_val;
    logic pin_out;
    logic pin_oe;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    rsp_state_t rsp_state;
    logic [5:0] rsp_idx;
    logic [7:0] rsp_byte;
  } dec_t;

  dec_t s_q, s_d;
  cmd_if cmd ();
  logic flag;
  logic detect_set;
  logic int_gate;
  logic flag_clear;
  logic [IRQ_W-1:0] events;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  report_capture u_capture (
    .clk_in(SYS_CLK_IN),
    .srst_in(SRST_IN),
    .byte_valid_in(CMD_BYTE_VALID_IN),
    .first_in(CMD_FIRST_IN),
    .byte_in(CMD_BYTE_IN),
    .cmd(cmd.src)
  );

  assign int_gate = cmd.commit && cmd.int_b[LOAD_BIT];
  assign flag_clear = int_gate && cmd.int_b[FLAG_CLR_BIT];

  int_edge_detect u_edge (
    .clk_in(SYS_CLK_IN),
    .srst_in(SRST_IN),
    .pin_in(INT_DETECT_PIN_IN),
    .rise_en_in(s_q.rise_en),
    .fall_en_in(s_q.fall_en),
    .clear_in(flag_clear),
    .flag_out(flag),
    .set_out(detect_set)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    events = '0;
    events[IRQ_APPLIED] = cmd.commit;
    events[IRQ_DETECT] = detect_set;
    events[IRQ_FOREIGN] = cmd.foreign;
    // Settings change only on a commit, all from one captured report
    if (cmd.commit) begin
      if (cmd.adc_b[LOAD_BIT]) begin
        s_d.adc_lvl = ref_level_t'(cmd.adc_b[ADC_LVL_LO +: 2]);
        s_d.adc_int = cmd.adc_b[ADC_SRC_BIT];
      end
      if (cmd.int_b[LOAD_BIT]) begin
        if (cmd.int_b[RISE_EN_BIT]) s_d.rise_en = cmd.int_b[RISE_VAL_BIT];
        if (cmd.int_b[FALL_EN_BIT]) s_d.fall_en = cmd.int_b[FALL_VAL_BIT];
      end
      if (cmd.gate_b[LOAD_BIT]) begin
        s_d.pin_des = cmd.pin_b[PIN_DES_LO +: 3];
        s_d.pin_dir = cmd.pin_b[PIN_DIR_BIT];
        s_d.pin_val = cmd.pin_b[PIN_VAL_BIT];
      end
    end
    // Pin zero function select
    unique case (s_q.pin_des)
      DES_GPIO: begin
        s_d.pin_out = s_q.pin_val;
        s_d.pin_oe = !s_q.pin_dir;
      end
      DES_SUSPEND: begin
        s_d.pin_out = SUSPEND_STATE_IN;
        s_d.pin_oe = 1'b1;
      end
      DES_RX_LED: begin
        s_d.pin_out = UART_RX_ACTIVE_IN;
        s_d.pin_oe = 1'b1;
      end
      default: begin
        s_d.pin_out = 1'b0;
        s_d.pin_oe = 1'b0;
      end
    endcase
    // Reply report
    unique case (s_q.rsp_state)
      RSP_IDLE: begin
        s_d.rsp_idx = '0;
      end
      RSP_SEND: begin
        s_d.rsp_idx = s_q.rsp_idx + 6'h01;
        s_d.rsp_byte = (s_q.rsp_idx == IDX_CODE) ? RESP_OK : RESP_FILL;
        if (s_q.rsp_idx == IDX_LAST) s_d.rsp_state = RSP_IDLE;
      end
    endcase
    if (cmd.commit) begin
      s_d.rsp_state = RSP_SEND;
      s_d.rsp_idx = '0;
      s_d.rsp_byte = CMD_SET_RUNTIME;
    end
    // Register port; a set in the same cycle as the read-clear survives
    s_d.rdata = '0;
    if (REG_WR_IN && REG_ADDR_IN == ADDR_IRQ_MASK) begin
      s_d.irq_mask = REG_WDATA_IN[IRQ_W-1:0];
    end
    s_d.irq_status = s_q.irq_status | events;
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        ADDR_IRQ_STATUS: begin
          s_d.rdata[IRQ_W-1:0] = s_q.irq_status;
          s_d.irq_status = events;
        end
        ADDR_IRQ_MASK: begin
          s_d.rdata[IRQ_W-1:0] = s_q.irq_mask;
        end
        ADDR_SETTINGS: begin
          s_d.rdata[SF_LVL +: 2] = s_q.adc_lvl;
          s_d.rdata[SF_SRC] = s_q.adc_int;
          s_d.rdata[SF_RISE] = s_q.rise_en;
          s_d.rdata[SF_FALL] = s_q.fall_en;
          s_d.rdata[SF_FLAG] = flag;
          s_d.rdata[SF_DES +: 3] = s_q.pin_des;
          s_d.rdata[SF_DIR] = s_q.pin_dir;
          s_d.rdata[SF_VAL] = s_q.pin_val;
          s_d.rdata[SF_PIN] = GENERAL_PIN_ZERO_IN;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      s_q <= '0;
      s_q.adc_lvl <= DEF_ADC_LEVEL;
      s_q.adc_int <= DEF_ADC_INTERNAL;
      s_q.rise_en <= DEF_RISE_EN;
      s_q.fall_en <= DEF_FALL_EN;
      s_q.pin_des <= DEF_PIN_DES;
      s_q.pin_dir <= DEF_PIN_DIR;
      s_q.pin_val <= DEF_PIN_VAL;
      s_q.irq_mask <= IRQ_MASK_RESET;
      s_q.rsp_state <= RSP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RESP_VALID_OUT = (s_q.rsp_state == RSP_SEND);
  assign RESP_LAST_OUT = (s_q.rsp_state == RSP_SEND) && (s_q.rsp_idx == IDX_LAST);
  assign RESP_BYTE_OUT = s_q.rsp_byte;
  assign ADC_REF_LEVEL_OUT = s_q.adc_lvl;
  assign ADC_REF_INTERNAL_OUT = s_q.adc_int;
  assign INT_DETECT_FLAG_OUT = flag;
  assign GENERAL_PIN_ZERO_OUT = s_q.pin_out;
  assign GENERAL_PIN_ZERO_OE_OUT = s_q.pin_oe;
  assign REG_RDATA_OUT = s_q.rdata;
  assign IRQ_OUT = |(s_q.irq_status & s_q.irq_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence reply_head;
    RESP_VALID_OUT && RESP_BYTE_OUT == CMD_SET_RUNTIME ##1
    RESP_VALID_OUT && RESP_BYTE_OUT == RESP_OK;
  endsequence

  // Last reply byte, then idle or the head of a reply to a newer command
  sequence reply_tail;
    (RESP_VALID_OUT && RESP_LAST_OUT) ##1
    (!RESP_VALID_OUT || RESP_BYTE_OUT == CMD_SET_RUNTIME);
  endsequence

  a_reply_echo_ok: assert property (cmd.commit |=> reply_head)
    else $error("reply did not start with echo and success");
  a_adc_load_new: assert property (
    cmd.commit && cmd.adc_b[LOAD_BIT] |=> ADC_REF_LEVEL_OUT == $past(cmd.adc_b[2:1])
    && ADC_REF_INTERNAL_OUT == $past(cmd.adc_b[0]))
    else $error("ADC reference not loaded from byte 5");
  a_settings_volatile_hold: assert property (
    !cmd.commit |=> $stable(ADC_REF_LEVEL_OUT) && $stable(s_q.rise_en)
    && $stable(s_q.pin_des))
    else $error("settings changed without a command");
  a_int_gate_closed: assert property (
    cmd.commit && !cmd.int_b[LOAD_BIT] |=> $stable(s_q.rise_en) && $stable(s_q.fall_en))
    else $error("edge settings changed with byte 6 gate closed");
  a_fall_update: assert property (
    int_gate && cmd.int_b[FALL_EN_BIT] |=> s_q.fall_en == $past(cmd.int_b[FALL_VAL_BIT]))
    else $error("falling edge enable not loaded");
  a_pin_gate_closed: assert property (
    cmd.commit && !cmd.gate_b[LOAD_BIT] |=> $stable(s_q.pin_des) && $stable(s_q.pin_val))
    else $error("pin settings changed with byte 7 gate closed");
  a_gpio_drive_out: assert property (
    s_q.pin_des == DES_GPIO && !s_q.pin_dir ##1 $stable(s_q.pin_val)
    |-> GENERAL_PIN_ZERO_OE_OUT && GENERAL_PIN_ZERO_OUT == s_q.pin_val)
    else $error("general output not driving its value");
  a_cmd_flag_clear: assert property (
    flag_clear |=> !INT_DETECT_FLAG_OUT || detect_set)
    else $error("detection flag survived a clear command");
  a_rise_update: assert property (
    int_gate && cmd.int_b[RISE_EN_BIT] |=> s_q.rise_en == $past(cmd.int_b[RISE_VAL_BIT]))
    else $error("rising edge enable not loaded");
  a_pin_load_new: assert property (
    cmd.commit && cmd.gate_b[LOAD_BIT] |=> s_q.pin_des == $past(cmd.pin_b[PIN_DES_LO +: 3])
    && s_q.pin_dir == $past(cmd.pin_b[PIN_DIR_BIT])
    && s_q.pin_val == $past(cmd.pin_b[PIN_VAL_BIT]))
    else $error("pin zero settings not loaded from byte 8");
  a_suspend_drive: assert property (
    s_q.pin_des == DES_SUSPEND |=> GENERAL_PIN_ZERO_OE_OUT
    && GENERAL_PIN_ZERO_OUT == $past(SUSPEND_STATE_IN))
    else $error("suspend indicator not driven on pin zero");
  a_rx_led_drive: assert property (
    s_q.pin_des == DES_RX_LED |=> GENERAL_PIN_ZERO_OE_OUT
    && GENERAL_PIN_ZERO_OUT == $past(UART_RX_ACTIVE_IN))
    else $error("receive activity not driven on pin zero");
  a_reply_length: assert property (cmd.commit |-> ##64 reply_tail)
    else $error("reply did not end after 64 bytes");
  a_irq_sticky_status: assert property (
    detect_set && !(REG_RD_IN && REG_ADDR_IN == ADDR_IRQ_STATUS) |=> s_q.irq_status[IRQ_DETECT])
    else $error("detection event lost from status");
endmodule : runtime_settings_decoder
`default_nettype wire

/* File: rts_host_model.sv */
/*
  Host side model: sends 64-byte settings reports one byte per strobe.
  Assumes the decoder samples the byte lines on the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rts_host_model (
  input wire logic clk_in,
  output logic valid_out,
  output logic first_out,
  output logic [7:0] byte_out
);
  initial begin
    valid_out = 1'b0;
    first_out = 1'b0;
    byte_out = 8'h00;
  end
  // ----------------------------------------------------------------
  // Report sender
  // ----------------------------------------------------------------
  task automatic send_report(input logic [7:0] code, input logic [7:0] b5, input logic [7:0] b6,
                             input logic [7:0] b7, input logic [7:0] b8, input int gap);
    logic [7:0] b;
    for (int i = 0; i < 64; i++) begin
      b = (i == 0) ? code : (i == 5) ? b5 : (i == 6) ? b6 : (i == 7) ? b7 : 8'h00;
      if (i == 8) begin
        b = (b8[2:0] > 3'h2) ? {b8[7:3], 3'h0} : b8;
      end
      @(posedge clk_in);
      valid_out <= 1'b1;
      first_out <= (i == 0);
      byte_out <= b;
      for (int g = 0; g < gap && i < 63; g++) begin
        @(posedge clk_in);
        valid_out <= 1'b0;
        first_out <= 1'b0;
        byte_out <= ~b;
      end
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    first_out <= 1'b0;
    byte_out <= ~byte_out;
  endtask : send_report
endmodule : rts_host_model
`default_nettype wire

/* File: runtime_settings_decoder_tb_top.sv */
/*
  Self-checking bench: host model sends reports, an integer model predicts
  settings, reply bytes, status and interrupt; results compared each command.
  Assumes the decoder with its default parameters and a 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module runtime_settings_decoder_tb_top;
  import rt_settings_pkg::*;
  logic clk, srst, pin_int, susp, rx_act, gp_in, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, seed;
  logic v, f, rvld, rlast, adc_int, flag, gp_out, gp_oe, irq;
  logic [7:0] bt, rbyte;
  logic [1:0] adc_lvl;
  int err_total, checks, e_lvl, e_int, e_rise, e_fall, e_flag, e_des, e_dir, e_val, e_mask;
  runtime_settings_decoder i_dut (.SYS_CLK_IN(clk), .SRST_IN(srst), .CMD_BYTE_VALID_IN(v),
    .CMD_FIRST_IN(f), .CMD_BYTE_IN(bt), .RESP_VALID_OUT(rvld), .RESP_LAST_OUT(rlast),
    .RESP_BYTE_OUT(rbyte), .ADC_REF_LEVEL_OUT(adc_lvl), .ADC_REF_INTERNAL_OUT(adc_int),
    .INT_DETECT_PIN_IN(pin_int), .INT_DETECT_FLAG_OUT(flag), .SUSPEND_STATE_IN(susp),
    .UART_RX_ACTIVE_IN(rx_act), .GENERAL_PIN_ZERO_IN(gp_in), .GENERAL_PIN_ZERO_OUT(gp_out),
    .GENERAL_PIN_ZERO_OE_OUT(gp_oe), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq));
  rts_host_model i_host (.clk_in(clk), .valid_out(v), .first_out(f), .byte_out(bt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt
  task automatic finish_test();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic defaults();
    {e_lvl, e_int, e_rise, e_fall, e_flag, e_des, e_dir, e_val, e_mask} = {9{32'd0}};
    e_dir = 1;
  endtask : defaults
  task automatic check_reply();
    int n;
    int q[$];
    n = 0;
    q = {32'h60};
    repeat (63) q.push_back(0);
    #1;
    while (rvld !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > 8) begin
        err_total++;
        finish_test();
      end
    end
    for (int i = 0; i < 64; i++) begin
      check(rbyte, q.pop_front());
      check(rlast, i == 63);
      @(posedge clk);
      #1;
    end
    check(rvld, 0);
  endtask : check_reply
  task automatic check_state(input int stat);
    logic [31:0] s;
    s = e_lvl | e_int << 2 | e_rise << 3 | e_fall << 4 | e_flag << 5 | e_des << 6;
    s = s | e_dir << 9 | e_val << 10 | gp_in << 16;
    check(adc_lvl, e_lvl);
    check(adc_int, e_int);
    check(flag, e_flag);
    check(gp_oe, (e_des == 1 || e_des == 2 || (e_des == 0 && e_dir == 0)));
    if (gp_oe === 1'b1) check(gp_out, e_des == 1 ? susp : e_des == 2 ? rx_act : e_val);
    reg_rd(ADDR_SETTINGS, rv);
    check(rv, s);
    check(irq, (stat & e_mask) != 0);
    reg_rd(ADDR_IRQ_STATUS, rv);
    check(rv, stat);
    check(irq, 0);
  endtask : check_state
  task automatic cmd(input logic [7:0] b5, input logic [7:0] b6, input logic [7:0] b7,
                     input logic [7:0] b8, input int gap);
    logic [7:0] d8;
    d8 = b8;
    if (d8[2:0] > 3'h2) d8[2:0] = 3'h0;
    i_host.send_report(CMD_SET_RUNTIME, b5, b6, b7, b8, gap);
    if (b5[7]) begin
      e_lvl = b5[2:1];
      e_int = b5[0];
    end
    if (b6[7] && b6[4]) e_rise = b6[3];
    if (b6[7] && b6[2]) e_fall = b6[1];
    if (b6[7] && b6[0]) e_flag = 0;
    if (b7[7]) begin
      e_des = d8[2:0];
      e_dir = d8[3];
      e_val = d8[4];
    end
    check_reply();
    check_state(1);
  endtask : cmd
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, pin_int, susp, rx_act, gp_in, wr, rd} = 7'h40;
    {addr, wdata, err_total, checks} = '0;
    seed = 32'hb3c8;
    defaults();
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    check_state(0);
    reg_wr(8'h0c, 32'hffff_ffff);
    reg_rd(8'h0c, rv);
    check(rv, 0);
    for (int i = 0; i < 24; i++) begin
      e_mask = nxt() & 7;
      reg_wr(ADDR_IRQ_MASK, e_mask);
      reg_wr(ADDR_IRQ_STATUS, 32'h7);
      reg_rd(ADDR_IRQ_MASK, rv);
      check(rv, e_mask);
      rv = nxt();
      @(posedge clk);
      {susp, rx_act, gp_in} <= rv[2:0];
      cmd(8'(nxt()), 8'(nxt()) & 8'hfe, 8'(nxt()), 8'(nxt()), i % 3);
    end
    cmd(8'h87, 8'h98, 8'h00, 8'h00, 0);
    @(posedge clk);
    pin_int <= 1'b1;
    repeat (4) @(posedge clk);
    e_flag = 1;
    #1 check(flag, 1);
    reg_rd(ADDR_IRQ_STATUS, rv);
    check(rv, 2);
    cmd(8'h05, 8'h01, 8'h00, 8'h00, 0);
    cmd(8'h80, 8'h81, 8'h00, 8'h00, 1);
    i_host.send_report(8'h61, 8'h83, 8'h81, 8'h80, 8'h01, 0);
    repeat (70) begin
      @(posedge clk);
      #1 check(rvld, 0);
    end
    check_state(4);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    defaults();
    check_state(0);
    finish_test();
  end
  initial begin
    #600000;
    err_total++;
    finish_test();
  end
endmodule : runtime_settings_decoder_tb_top
`default_nettype wire
